// *** rtl/dbgsel_pkg.sv ***
// constants, types and the crc decode helper for the debug register select block
package dbgsel_pkg;
  // select codes of the data registers
  localparam logic [7:0] SEL_RESET       = 8'h00;
  localparam logic [7:0] SEL_DEVICE_ID   = 8'h00;
  localparam logic [7:0] SEL_REVISION_ID = 8'h01;
  localparam logic [7:0] SEL_FLASH_CTL   = 8'h02;
  localparam logic [7:0] SEL_FLASH_DATA  = 8'hbf;
  localparam logic [7:0] SEL_CRC_AUTO    = 8'hd2;
  localparam logic [7:0] SEL_CRC_COUNT   = 8'hd3;
  localparam logic [7:0] SEL_CRC_CTL     = 8'hce;
  localparam logic [7:0] SEL_CRC_RESULT  = 8'hde;
  localparam logic [7:0] SEL_CRC_REVERSE = 8'hcf;
  localparam logic [7:0] SEL_CRC_INPUT   = 8'hdd;
  // flash programming values and the unmapped read value
  localparam logic [7:0] FLASH_CTL_RESET    = 8'h00;
  localparam logic [7:0] FLASH_KEY_FIRST    = 8'h02;
  localparam logic [7:0] FLASH_KEY_SECOND   = 8'h01;
  localparam logic [7:0] FLASH_CMD_BLK_RD   = 8'h06;
  localparam logic [7:0] FLASH_CMD_BLK_WR   = 8'h07;
  localparam logic [7:0] FLASH_CMD_PG_ERASE = 8'h08;
  localparam logic [7:0] FLASH_CMD_DV_ERASE = 8'h03;
  localparam logic [7:0] RD_UNMAPPED        = 8'h00;
  // crc unit register index
  typedef logic [2:0] dbgsel_crc_idx_t;
  localparam dbgsel_crc_idx_t CRC_IDX_AUTO    = 3'h0;
  localparam dbgsel_crc_idx_t CRC_IDX_COUNT   = 3'h1;
  localparam dbgsel_crc_idx_t CRC_IDX_CTL     = 3'h2;
  localparam dbgsel_crc_idx_t CRC_IDX_RESULT  = 3'h3;
  localparam dbgsel_crc_idx_t CRC_IDX_REVERSE = 3'h4;
  localparam dbgsel_crc_idx_t CRC_IDX_INPUT   = 3'h5;
  // link command codes, bit 0 sent first
  localparam logic [1:0] CMD_DATA_RD = 2'h0;
  localparam logic [1:0] CMD_DATA_WR = 2'h1;
  localparam logic [1:0] CMD_ADDR_RD = 2'h2;
  localparam logic [1:0] CMD_ADDR_WR = 2'h3;
  // link bit counts, as last index
  localparam logic [2:0] CMD_LAST  = 3'h1;
  localparam logic [2:0] DATA_LAST = 3'h7;
  typedef enum logic [2:0] {L_CMD, L_WDATA, L_WAIT, L_RDATA, L_TURN} dbgsel_link_e;
  typedef enum logic {C_IDLE, C_READ} dbgsel_core_e;
  // {hit, index} of a crc unit select code
  function automatic logic [3:0] dbgsel_crc_decode(input logic [7:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      SEL_CRC_AUTO:    r = {1'b1, CRC_IDX_AUTO};
      SEL_CRC_COUNT:   r = {1'b1, CRC_IDX_COUNT};
      SEL_CRC_CTL:     r = {1'b1, CRC_IDX_CTL};
      SEL_CRC_RESULT:  r = {1'b1, CRC_IDX_RESULT};
      SEL_CRC_REVERSE: r = {1'b1, CRC_IDX_REVERSE};
      SEL_CRC_INPUT:   r = {1'b1, CRC_IDX_INPUT};
      default:         r = 4'h0;
    endcase
    return r;
  endfunction : dbgsel_crc_decode
endpackage : dbgsel_pkg

// *** rtl/dbgsel_xfer_if.sv ***
// request and answer carrier between link and register logic
`timescale 1ns/1ps
interface dbgsel_xfer_if;
  logic       req_tgl;
  logic [1:0] cmd;
  logic [7:0] wdata;
  logic       ack_tgl;
  logic [7:0] rdata;
  modport link (output req_tgl, output cmd, output wdata, input ack_tgl, input rdata);
  modport core (input req_tgl, input cmd, input wdata, output ack_tgl, output rdata);
endinterface : dbgsel_xfer_if

// *** rtl/dbgsel_link.sv ***
// serial link engine on the debug clock
`timescale 1ns/1ps
module dbgsel_link (
  // link clock and reset
  input  wire logic   i_link_clk,
  input  wire logic   i_resetn,
  // data pin
  input  wire logic   i_data,
  output logic        o_data,
  output logic        o_data_oe,
  // to register logic
  dbgsel_xfer_if.link x
);
  import dbgsel_pkg::*;

  logic         rst_s1_q, rst_s2_q;
  logic         ack_s1_q, ack_s2_q;
  dbgsel_link_e st_q, st_d;
  logic [2:0]   cnt_q, cnt_d;
  logic [1:0]   cmd_q, cmd_d;
  logic [7:0]   wsh_q, wsh_d;
  logic [7:0]   rsh_q, rsh_d;
  logic         req_q, req_d;
  logic         out_q, out_d;
  logic         oe_q, oe_d;
  logic         ready;

  // reset release and answer toggle synchronisers
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge i_link_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= x.ack_tgl;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign ready = (ack_s2_q == req_q);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    wsh_d = wsh_q;
    rsh_d = rsh_q;
    req_d = req_q;
    out_d = out_q;
    oe_d  = 1'b0;
    unique case (st_q)
      L_CMD: begin
        cmd_d = {i_data, cmd_q[1]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CMD_LAST) begin
          cnt_d = 3'h0;
          if (cmd_d[0]) begin
            st_d = L_WDATA;
          end else begin
            req_d = ~req_q;
            st_d  = L_WAIT;
            oe_d  = 1'b1;
            out_d = 1'b0;
          end
        end
      end
      L_WDATA: begin
        wsh_d = {i_data, wsh_q[7:1]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == DATA_LAST) begin
          cnt_d = 3'h0;
          req_d = ~req_q;
          st_d  = L_WAIT;
          oe_d  = 1'b1;
          out_d = 1'b0;
        end
      end
      L_WAIT: begin
        oe_d  = 1'b1; // R12
        out_d = ready;
        if (ready) begin
          rsh_d = x.rdata;
          st_d  = cmd_q[0] ? L_TURN : L_RDATA;
        end
      end
      L_RDATA: begin
        oe_d  = 1'b1;
        out_d = rsh_q[0];
        rsh_d = {1'b0, rsh_q[7:1]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == DATA_LAST) begin
          cnt_d = 3'h0;
          st_d  = L_TURN;
        end
      end
      L_TURN: st_d = L_CMD;
      default: st_d = L_CMD;
    endcase
  end

  always_ff @(posedge i_link_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      st_q  <= L_CMD;
      cnt_q <= 3'h0;
      cmd_q <= 2'h0;
      wsh_q <= 8'h00;
      rsh_q <= 8'h00;
      req_q <= 1'b0;
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      wsh_q <= wsh_d;
      rsh_q <= rsh_d;
      req_q <= req_d;
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign x.req_tgl = req_q;
  assign x.cmd     = cmd_q;
  assign x.wdata   = wsh_q;
  assign o_data    = out_q;
  assign o_data_oe = oe_q;

  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (!rst_s2_q);

  pin_released_a: assert property ( // R12
    (st_q == L_CMD || st_q == L_WDATA) |-> !o_data_oe)
    else $error("data pin driven while adapter owns it");
  ready_bit_a: assert property ( // R12
    (st_q == L_WAIT && ready) |=> (o_data_oe && o_data))
    else $error("ready bit not driven high");
endmodule : dbgsel_link

// *** rtl/dbgsel_top.sv ***
// debug register select, identification and routing core
`timescale 1ns/1ps
// Operation
// R1 - An 8-bit select register, written and read over the debug link, picks the data register.
// R2 - Select 0x00 reads the device identifier, which ignores data writes.
// R3 - Select 0x01 reaches the revision identifier, which ignores data writes.
// R4 - Select 0x02 reads and writes the flash programming control register.
// R5 - Select 0xbf reads and writes the flash programming data register.
// R6 - Selects 0xd2, 0xd3 and 0xce reach crc auto control, block count and control.
// R7 - Selects 0xde, 0xcf and 0xdd reach crc result, bit reverse and input.
// R8 - The device identifier reads a fixed 8-bit code the adapter cannot change.
// R9 - The revision identifier reads an 8-bit revision code, zero for the first.
// R10 - Writing 0x02 then 0x01 to flash control enables programming until reset.
// R11 - Flash data accepts codes 0x06, 0x07, 0x08 and 0x03 as commands.
// R12 - The link has one clock input from the adapter and one shared data pin.
// R13 - The select register holds its value until rewritten or reset.
module dbgsel_top #(
  parameter logic [7:0] DEVICE_ID   = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h00
) (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_resetn,
  // debug link pins
  input  wire logic                   i_debug_clock_pin,
  input  wire logic                   i_debug_data_pin,
  output logic                        o_debug_data_pin,
  output logic                        o_debug_data_pin_oe,
  // flash programming side
  output logic                        o_flash_prog_en,
  output logic [7:0]                  o_flash_program_control,
  output logic                        o_flash_cmd_valid,
  output logic                        o_flash_wr,
  output logic                        o_flash_rd,
  output logic [7:0]                  o_flash_wdata,
  input  wire logic [7:0]             i_flash_rdata,
  input  wire logic                   i_flash_idle,
  // crc unit side
  output logic                        o_crc_wr,
  output logic                        o_crc_rd,
  output dbgsel_pkg::dbgsel_crc_idx_t o_crc_sel,
  output logic [7:0]                  o_crc_wdata,
  input  wire logic [7:0]             i_crc_rdata,
  // status
  output logic [7:0]                  o_debug_register_select
);
  import dbgsel_pkg::*;

  dbgsel_xfer_if xfer ();

  dbgsel_link u_link (
    .i_link_clk (i_debug_clock_pin),
    .i_resetn   (i_resetn),
    .i_data     (i_debug_data_pin),
    .o_data     (o_debug_data_pin),
    .o_data_oe  (o_debug_data_pin_oe),
    .x          (xfer.link)
  );

  logic            req_s1_q, req_s2_q, req_s3_q;
  logic            req_evt;
  dbgsel_core_e    st_q, st_d;
  logic [7:0]      sel_q, sel_d;
  logic [7:0]      fpc_q, fpc_d;
  logic            key_q, key_d;
  logic            prog_q, prog_d;
  logic            cph_q, cph_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            ack_q, ack_d;
  logic            fcmd_q, fcmd_d;
  logic            fwr_q, fwr_d;
  logic            frd_q, frd_d;
  logic [7:0]      fwd_q, fwd_d;
  logic            cwr_q, cwr_d;
  logic            crd_q, crd_d;
  dbgsel_crc_idx_t csel_q, csel_d;
  logic [7:0]      cwd_q, cwd_d;
  logic [3:0]      crc_dec;
  logic            fcode_ok;

  // request toggle synchroniser
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= xfer.req_tgl;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  assign req_evt = req_s2_q ^ req_s3_q;
  assign crc_dec = dbgsel_crc_decode(sel_q);

  // flash command code check
  always_comb begin
    unique case (xfer.wdata)
      FLASH_CMD_BLK_RD, FLASH_CMD_BLK_WR,
      FLASH_CMD_PG_ERASE, FLASH_CMD_DV_ERASE: fcode_ok = 1'b1; // R11
      default: fcode_ok = 1'b0;
    endcase
  end

  always_comb begin
    st_d    = st_q;
    sel_d   = sel_q;
    fpc_d   = fpc_q;
    key_d   = key_q;
    prog_d  = prog_q;
    cph_d   = cph_q;
    rdata_d = rdata_q;
    ack_d   = ack_q;
    fwd_d   = fwd_q;
    csel_d  = csel_q;
    cwd_d   = cwd_q;
    fcmd_d  = 1'b0;
    fwr_d   = 1'b0;
    frd_d   = 1'b0;
    cwr_d   = 1'b0;
    crd_d   = 1'b0;
    unique case (st_q)
      C_IDLE: begin
        if (req_evt) begin
          unique case (xfer.cmd)
            CMD_ADDR_WR: begin
              sel_d = xfer.wdata; // R1
              ack_d = ~ack_q;
            end
            CMD_ADDR_RD: begin
              rdata_d = sel_q; // R1
              ack_d   = ~ack_q;
            end
            CMD_DATA_WR: begin
              ack_d = ~ack_q;
              if (sel_q == SEL_FLASH_CTL) begin
                fpc_d = xfer.wdata; // R4
                key_d = (xfer.wdata == FLASH_KEY_FIRST); // R10
                if (key_q && xfer.wdata == FLASH_KEY_SECOND) begin
                  prog_d = 1'b1; // R10
                end
              end else if (sel_q == SEL_FLASH_DATA && prog_q) begin
                fwd_d = xfer.wdata; // R5
                if (!cph_q) begin
                  fwr_d = 1'b1;
                end else if (fcode_ok) begin
                  fcmd_d = 1'b1; // R11
                  cph_d  = 1'b0;
                end
              end else if (crc_dec[3]) begin
                cwr_d  = 1'b1; // R6 R7
                csel_d = crc_dec[2:0];
                cwd_d  = xfer.wdata;
              end
            end
            CMD_DATA_RD: begin
              st_d = C_READ;
              if (sel_q == SEL_FLASH_DATA) begin
                frd_d = prog_q; // R5
              end
              if (crc_dec[3]) begin
                crd_d  = 1'b1; // R6 R7
                csel_d = crc_dec[2:0];
              end
            end
          endcase
        end
      end
      C_READ: begin
        st_d  = C_IDLE;
        ack_d = ~ack_q;
        unique case (sel_q)
          SEL_DEVICE_ID:   rdata_d = DEVICE_ID; // R2 R8
          SEL_REVISION_ID: rdata_d = REVISION_ID; // R3 R9
          SEL_FLASH_CTL:   rdata_d = fpc_q; // R4
          SEL_FLASH_DATA:  rdata_d = i_flash_rdata; // R5
          default:         rdata_d = crc_dec[3] ? i_crc_rdata : RD_UNMAPPED;
        endcase
      end
    endcase
    if (i_flash_idle) begin
      cph_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q    <= C_IDLE;
      sel_q   <= SEL_RESET;
      fpc_q   <= FLASH_CTL_RESET;
      key_q   <= 1'b0;
      prog_q  <= 1'b0;
      cph_q   <= 1'b1;
      rdata_q <= 8'h00;
      ack_q   <= 1'b0;
      fcmd_q  <= 1'b0;
      fwr_q   <= 1'b0;
      frd_q   <= 1'b0;
      fwd_q   <= 8'h00;
      cwr_q   <= 1'b0;
      crd_q   <= 1'b0;
      csel_q  <= CRC_IDX_AUTO;
      cwd_q   <= 8'h00;
    end else begin
      st_q    <= st_d;
      sel_q   <= sel_d; // R13
      fpc_q   <= fpc_d;
      key_q   <= key_d;
      prog_q  <= prog_d;
      cph_q   <= cph_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      fcmd_q  <= fcmd_d;
      fwr_q   <= fwr_d;
      frd_q   <= frd_d;
      fwd_q   <= fwd_d;
      cwr_q   <= cwr_d;
      crd_q   <= crd_d;
      csel_q  <= csel_d;
      cwd_q   <= cwd_d;
    end
  end

  assign xfer.ack_tgl            = ack_q;
  assign xfer.rdata              = rdata_q;
  assign o_flash_prog_en         = prog_q;
  assign o_flash_program_control = fpc_q;
  assign o_flash_cmd_valid       = fcmd_q;
  assign o_flash_wr              = fwr_q;
  assign o_flash_rd              = frd_q;
  assign o_flash_wdata           = fwd_q;
  assign o_crc_wr                = cwr_q;
  assign o_crc_rd                = crd_q;
  assign o_crc_sel               = csel_q;
  assign o_crc_wdata             = cwd_q;
  assign o_debug_register_select = sel_q;

  // checks
  logic take;
  logic wr_evt;
  logic rd_evt;
  assign take   = req_evt && st_q == C_IDLE;
  assign wr_evt = take && xfer.cmd == CMD_DATA_WR;
  assign rd_evt = take && xfer.cmd == CMD_DATA_RD;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_key_first;
    wr_evt && sel_q == SEL_FLASH_CTL && xfer.wdata == FLASH_KEY_FIRST;
  endsequence
  sequence s_key_second;
    wr_evt && sel_q == SEL_FLASH_CTL && xfer.wdata == FLASH_KEY_SECOND;
  endsequence

  sel_write_a: assert property ( // R1
    (take && xfer.cmd == CMD_ADDR_WR) |=> sel_q == $past(xfer.wdata))
    else $error("select register not loaded");
  sel_read_a: assert property ( // R1
    (take && xfer.cmd == CMD_ADDR_RD) |=> xfer.rdata == $past(sel_q))
    else $error("select register read wrong");
  sel_hold_a: assert property ( // R13
    !(take && xfer.cmd == CMD_ADDR_WR) |=> $stable(sel_q))
    else $error("select register changed without a write");
  id_read_a: assert property ( // R2 R8
    (rd_evt && sel_q == SEL_DEVICE_ID) |-> ##2 (xfer.rdata == DEVICE_ID
      && xfer.ack_tgl != $past(xfer.ack_tgl, 2)))
    else $error("device identifier read wrong");
  rev_read_a: assert property ( // R3 R9
    (rd_evt && sel_q == SEL_REVISION_ID) |-> ##2 (xfer.rdata == REVISION_ID))
    else $error("revision identifier read wrong");
  id_nowrite_a: assert property ( // R2 R3
    (wr_evt && sel_q <= SEL_REVISION_ID) |=> (!o_flash_wr && !o_crc_wr
      && !o_flash_cmd_valid && $stable(fpc_q)))
    else $error("write to identifier had an effect");
  fpc_write_a: assert property ( // R4
    (wr_evt && sel_q == SEL_FLASH_CTL) |=> o_flash_program_control == $past(xfer.wdata))
    else $error("flash control not written");
  key_arm_a: assert property ( // R10
    s_key_first |=> key_q)
    else $error("first key not remembered");
  prog_set_a: assert property ( // R10
    (key_q ##0 s_key_second) |=> o_flash_prog_en)
    else $error("programming not enabled by key pair");
  prog_keep_a: assert property ( // R10
    o_flash_prog_en |=> o_flash_prog_en)
    else $error("programming enable dropped before reset");
  flash_cmd_a: assert property ( // R5 R11
    (wr_evt && sel_q == SEL_FLASH_DATA && prog_q && cph_q && fcode_ok)
      |=> (o_flash_cmd_valid && o_flash_wdata == $past(xfer.wdata) && !o_flash_wr))
    else $error("flash command not accepted");
  crc_auto_a: assert property ( // R6
    (wr_evt && sel_q == SEL_CRC_AUTO) |=> (o_crc_wr && o_crc_sel == CRC_IDX_AUTO))
    else $error("crc auto control not routed");
  crc_count_a: assert property ( // R6
    (wr_evt && sel_q == SEL_CRC_COUNT) |=> (o_crc_wr && o_crc_sel == CRC_IDX_COUNT))
    else $error("crc block count not routed");
  crc_input_a: assert property ( // R7
    (rd_evt && sel_q == SEL_CRC_INPUT) |=> (o_crc_rd && o_crc_sel == CRC_IDX_INPUT))
    else $error("crc input not routed");
  crc_flip_a: assert property ( // R7
    (rd_evt && sel_q == SEL_CRC_REVERSE)
      |=> (o_crc_rd && o_crc_sel == CRC_IDX_REVERSE) ##1 xfer.rdata == $past(i_crc_rdata))
    else $error("crc bit reverse not routed");
endmodule : dbgsel_top

// *** sim/dbgsel_adapter.sv ***
// partner model of the debug adapter: link clock, shared data pin and framing
`timescale 1ns/1ps
module dbgsel_adapter (
  // device drive of the data pin
  input  wire logic i_dev_data,
  input  wire logic i_dev_oe,
  // link pins as seen at the device
  output logic      o_clk,
  output logic      o_wire,
  // both parties drove the pin at one edge
  output logic      o_clash
);
  logic drv_en;
  logic drv_val;
  logic idle_v;
  initial begin
    o_clk   = 1'b0;
    o_clash = 1'b0;
    drv_en  = 1'b0;
    drv_val = 1'b0;
    idle_v  = 1'b1;
  end
  // released pin shows the inverse of its last level
  assign o_wire = i_dev_oe ? i_dev_data : (drv_en ? drv_val : idle_v);
  always @(o_wire) begin
    if (i_dev_oe === 1'b1 || drv_en) idle_v = ~o_wire;
  end
  always @(posedge o_clk) begin
    if (i_dev_oe === 1'b1 && drv_en) o_clash = 1'b1;
  end
  // one link period, clock low between frames
  task automatic pulse();
    #32;
    o_clk = 1'b1;
    #32;
    o_clk = 1'b0;
  endtask : pulse
  task automatic idle(input int n);
    repeat (n) pulse();
  endtask : idle
  // command, optional write byte, bounded busy wait, optional read byte, turnaround
  task automatic xfer(input logic [1:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int k;
    rd = 8'h00;
    ok = 1'b0;
    #1.3;
    drv_en = 1'b1;
    for (k = 0; k < 2; k++) begin
      drv_val = cmd[k];
      pulse();
    end
    if (cmd[0]) begin
      for (k = 0; k < 8; k++) begin
        drv_val = wd[k];
        pulse();
      end
    end
    drv_en = 1'b0;
    for (k = 0; k < 200 && !ok; k++) begin
      pulse();
      ok = (o_wire === 1'b1);
    end
    if (ok && !cmd[0]) begin
      for (k = 0; k < 8; k++) begin
        pulse();
        rd[k] = o_wire;
      end
    end
    pulse();
  endtask : xfer
endmodule : dbgsel_adapter

// *** sim/dbgsel_top_tb.sv ***
// self-checking bench of the debug register select block
`timescale 1ns/1ps
module dbgsel_top_tb;
  import dbgsel_pkg::*;
  logic            i_ref_clk     = 1'b0;
  logic            i_resetn      = 1'b1;
  logic [7:0]      i_flash_rdata = 8'h00;
  logic            i_flash_idle  = 1'b0;
  logic [7:0]      i_crc_rdata   = 8'h00;
  logic            link_clk, link_wire, dev_out, dev_oe, clash;
  logic            prog_en, fcmd, fwr, frd, crc_wr, crc_rd;
  logic [7:0]      fctl, fwdata, crc_wdata, sel, crc_wd_seen;
  dbgsel_crc_idx_t crc_sel, crc_sel_seen;
  int              n_fail = 0, n_compared = 0;
  int              n_crc_wr = 0, n_crc_rd = 0, n_fcmd = 0, n_fwr = 0, n_frd = 0;
  logic [7:0]      crc_code [6] = '{8'hd2, 8'hd3, 8'hce, 8'hde, 8'hcf, 8'hdd};
  logic [2:0]      crc_idx  [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [7:0]      fl_code  [4] = '{8'h06, 8'h07, 8'h08, 8'h03};

  always #2.5 i_ref_clk = ~i_ref_clk;

  dbgsel_top #(.DEVICE_ID(8'h96), .REVISION_ID(8'h00)) i_dbgsel_top ( // 8'h96 arbitrary
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_debug_clock_pin(link_clk), .i_debug_data_pin(link_wire),
    .o_debug_data_pin(dev_out), .o_debug_data_pin_oe(dev_oe),
    .o_flash_prog_en(prog_en), .o_flash_program_control(fctl),
    .o_flash_cmd_valid(fcmd), .o_flash_wr(fwr), .o_flash_rd(frd),
    .o_flash_wdata(fwdata), .i_flash_rdata(i_flash_rdata), .i_flash_idle(i_flash_idle),
    .o_crc_wr(crc_wr), .o_crc_rd(crc_rd), .o_crc_sel(crc_sel),
    .o_crc_wdata(crc_wdata), .i_crc_rdata(i_crc_rdata),
    .o_debug_register_select(sel));

  dbgsel_adapter i_dbgsel_adapter (
    .i_dev_data(dev_out), .i_dev_oe(dev_oe),
    .o_clk(link_clk), .o_wire(link_wire), .o_clash(clash));

  // strobe monitors
  always @(posedge i_ref_clk) begin
    if (crc_wr === 1'b1) begin
      n_crc_wr++;
      crc_sel_seen = crc_sel;
      crc_wd_seen  = crc_wdata;
    end
    if (crc_rd === 1'b1) begin
      n_crc_rd++;
      crc_sel_seen = crc_sel;
    end
    if (fcmd === 1'b1) n_fcmd++;
    if (fwr === 1'b1) n_fwr++;
    if (frd === 1'b1) n_frd++;
  end

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic link(input logic [1:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic ok;
    i_dbgsel_adapter.xfer(cmd, wd, rd, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t no ready answer on the link", $time);
      give_verdict();
    end
  endtask : link

  task automatic sel_wr(input logic [7:0] v);
    logic [7:0] d;
    link(CMD_ADDR_WR, v, d);
  endtask : sel_wr
  task automatic dat_wr(input logic [7:0] v);
    logic [7:0] d;
    link(CMD_DATA_WR, v, d);
  endtask : dat_wr
  task automatic dat_rd(output logic [7:0] v);
    link(CMD_DATA_RD, 8'h00, v);
  endtask : dat_rd
  task automatic sel_rd(output logic [7:0] v);
    link(CMD_ADDR_RD, 8'h00, v);
  endtask : sel_rd

  task automatic do_reset();
    @(posedge i_ref_clk) i_resetn <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    i_dbgsel_adapter.idle(2);
    repeat (3) @(posedge i_ref_clk);
  endtask : do_reset

  task automatic idle_pulse();
    @(posedge i_ref_clk) i_flash_idle <= 1'b1;
    @(posedge i_ref_clk) i_flash_idle <= 1'b0;
  endtask : idle_pulse

  initial begin
    logic [7:0] d;
    do_reset();
    // reset state and identification
    check(sel, 8'h00, "select after reset");
    check({7'h00, prog_en}, 8'h00, "programming after reset");
    check(fctl, 8'h00, "flash control after reset");
    sel_rd(d);
    check(d, 8'h00, "select read after reset");
    dat_rd(d);
    check(d, 8'h96, "device id");
    dat_wr(8'h69);
    dat_rd(d);
    check(d, 8'h96, "device id after write");
    sel_wr(8'h01);
    dat_wr(8'hff);
    dat_rd(d);
    check(d, 8'h00, "revision id");
    $display("test identification done");
    // crc routing table and an unmapped select
    for (int i = 0; i < 6; i++) begin
      sel_wr(crc_code[i]);
      sel_rd(d);
      check(d, crc_code[i], "select readback");
      dat_wr(8'h40 + 8'(i));
      check(8'(n_crc_wr), 8'(i + 1), "crc write strobes");
      check({5'h00, crc_sel_seen}, {5'h00, crc_idx[i]}, "crc write index");
      check(crc_wd_seen, 8'h40 + 8'(i), "crc write data");
      @(posedge i_ref_clk) i_crc_rdata <= 8'hc0 + 8'(i);
      dat_rd(d);
      check(d, 8'hc0 + 8'(i), "crc read data");
      check(8'(n_crc_rd), 8'(i + 1), "crc read strobes");
      check({5'h00, crc_sel_seen}, {5'h00, crc_idx[i]}, "crc read index");
    end
    sel_wr(8'h55);
    dat_wr(8'hff);
    dat_rd(d);
    check(d, 8'h00, "unmapped read");
    check(8'(n_crc_wr), 8'h06, "unmapped write routed");
    $display("test crc routing done");
    // flash control key pair
    sel_wr(8'hbf);
    dat_wr(8'h07);
    check(8'(n_fcmd), 8'h00, "command while locked");
    sel_wr(8'h02);
    dat_wr(8'h02);
    dat_wr(8'h05);
    dat_wr(8'h01);
    check({7'h00, prog_en}, 8'h00, "broken key pair");
    dat_wr(8'h02);
    dat_rd(d);
    check(d, 8'h02, "flash control readback");
    dat_wr(8'h01);
    check({7'h00, prog_en}, 8'h01, "key pair enables");
    check(fctl, 8'h01, "flash control output");
    $display("test flash control done");
    // flash data commands, operands and read
    sel_wr(8'hbf);
    for (int i = 0; i < 4; i++) begin
      dat_wr(fl_code[i]);
      check(8'(n_fcmd), 8'(i + 1), "flash command");
      check(fwdata, fl_code[i], "flash command code");
      dat_wr(8'h3c + 8'(i));
      check(8'(n_fwr), 8'(i + 1), "flash operand");
      check(fwdata, 8'h3c + 8'(i), "flash operand data");
      idle_pulse();
    end
    dat_wr(8'h11);
    check(8'(n_fcmd), 8'h04, "unknown code");
    check(8'(n_fwr), 8'h04, "unknown code as operand");
    @(posedge i_ref_clk) i_flash_rdata <= 8'h7e;
    dat_rd(d);
    check(d, 8'h7e, "flash data read");
    check(8'(n_frd), 8'h01, "flash read strobe");
    sel_rd(d);
    check(d, 8'hbf, "select kept");
    check(sel, 8'hbf, "select output kept");
    $display("test flash data done");
    // second reset clears select and programming
    do_reset();
    check(sel, 8'h00, "select after second reset");
    check({7'h00, prog_en}, 8'h00, "programming after second reset");
    dat_rd(d);
    check(d, 8'h96, "device id after second reset");
    check({7'h00, clash}, 8'h00, "pin driven by both");
    $display("test second reset done");
    give_verdict();
  end
endmodule : dbgsel_top_tb
